// >>> serial_flash_spi_frontend_test.sv
/*
   Self-checking bench of the command front end with a master model.
   Assumes package, design, checker and model are compiled before it.
*/
`default_nettype none

module serial_flash_spi_frontend_test import sfs_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   logic ref_clk_i = 0;
   logic reset_n_i = 0;
   logic sck, cs_n, si, hold_n, so, so_oe_n;
   logic wp_n_i = 1, busy_i = 0, tx_load_i = 0, cpol = 0;
   logic [SECT_CNT-1:0] sect_prot_i = '0;
   logic [7:0] tx_byte_i = '0;
   logic cmd_valid_o, cmd_blocked_o, rx_valid_o, frame_end_o;
   logic hold_o, wp_lock_o, standby_o, last_blk;
   logic [7:0] rx_byte_o, last_rx;
   sfs_cmd_t cmd_o, last_cmd;
   int errors = 0, n_compared = 0, n_cmd = 0, n_rx = 0, n_end = 0;
   int hold_at = -1;

   sfs_frontend dut_u (
      .ref_clk_i, .reset_n_i, .sck_i(sck), .cs_n_i(cs_n), .si_i(si),
      .hold_n_i(hold_n), .wp_n_i, .busy_i, .sect_prot_i, .tx_byte_i,
      .tx_load_i, .so_o(so), .so_oe_n_o(so_oe_n), .cmd_valid_o, .cmd_o,
      .cmd_blocked_o, .rx_valid_o, .rx_byte_o, .frame_end_o, .hold_o,
      .wp_lock_o, .standby_o
   );
   sfs_master_model u_m (
      .cpol_i(cpol), .so_i(so), .so_oe_n_i(so_oe_n), .sck_o(sck),
      .cs_n_o(cs_n), .si_o(si), .hold_n_o(hold_n)
   );

   always #2 ref_clk_i = ~ref_clk_i;

   always @(negedge ref_clk_i) begin
      if (cmd_valid_o === 1'b1) begin
         n_cmd++;
         last_cmd = cmd_o;
         last_blk = cmd_blocked_o;
      end
      if (rx_valid_o === 1'b1) begin
         n_rx++;
         last_rx = rx_byte_o;
      end
      if (frame_end_o === 1'b1) n_end++;
   end

   task automatic chk(input logic [40:0] got, input logic [40:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic finish_test();
      $display("errors %0d compared %0d", errors, n_compared);
      if (errors == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic frame(input logic [7:0] q [$]);
      int e;
      e = n_end;
      u_m.sel();
      foreach (q[i]) begin
         if (i == hold_at) begin
            u_m.bits(q[i], 4);
            u_m.hold_on();
            @(negedge ref_clk_i);
            chk({hold_o, so_oe_n}, 2'b11);
            u_m.hold_off();
            u_m.bits(q[i] << 4, 4);
         end else begin
            u_m.bits(q[i], 8);
         end
      end
      u_m.desel();
      for (int k = 0; k < 20 && n_end == e; k++) @(negedge ref_clk_i);
      @(negedge ref_clk_i);
      chk(n_end, e + 1);
   endtask

   task automatic t_read();
      int c;
      c = n_cmd;
      fork
         frame('{OP_RD_SLOW, 8'hF2, 8'h34, 8'h56, 8'h00, 8'h00});
         begin
            wait (n_cmd != c);
            @(negedge ref_clk_i);
            tx_byte_i = 8'hA5;
            tx_load_i = 1;
            @(negedge ref_clk_i);
            tx_load_i = 0;
         end
      join
      chk(n_cmd, c + 1);
      chk(last_cmd.addr, 20'h23456);
      chk(last_cmd.cls, OC_READ);
      chk(u_m.rx, 8'hA5);
   endtask

   task automatic t_erase();
      logic [7:0] op [5] = '{OP_ERS_4K, OP_ERS_32K, OP_ERS_64K,
         OP_ERS_CHIP_A, OP_ERS_CHIP_B};
      logic [7:0] ah [3] = '{8'h40, 8'h60, 8'h80};
      sfs_ers_t er [5] = '{ERS_4K, ERS_32K, ERS_64K, ERS_CHIP, ERS_CHIP};
      logic [4:0] sc [3] = '{SECT_8K_LO, SECT_8K_HI, SECT_32K};
      cpol = 1;
      sect_prot_i = 19'h2_0000;
      for (int i = 0; i < 5; i++) begin
         if (i < 3) begin
            frame('{op[i], 8'h0F, ah[i], 8'h00});
            chk(last_cmd.sect, sc[i]);
         end else begin
            frame('{op[i]});
         end
         chk(last_blk, i != 0);
         chk(last_cmd.ers, er[i]);
      end
      cpol = 0;
   endtask

   task automatic t_unsup();
      int c;
      c = n_cmd;
      frame('{8'hFF, OP_RD_SLOW, 8'h00, 8'h00, 8'h00});
      chk(n_cmd, c);
      frame('{OP_WR_EN});
      chk(last_cmd.op, OP_WR_EN);
   endtask

   task automatic t_partial();
      int c;
      int r;
      c = n_cmd;
      frame('{OP_PROG, 8'h01, 8'h02});
      chk(n_cmd, c);
      r = n_rx;
      frame('{OP_PROG, 8'h01, 8'h02, 8'h03, 8'h3C});
      chk(last_cmd.addr, 20'h10203);
      chk(n_rx, r + 1);
      chk(last_rx, 8'h3C);
   endtask

   task automatic t_hold();
      hold_at = 4;
      busy_i = 1;
      frame('{OP_PROG, 8'h00, 8'h12, 8'h34, 8'h96});
      hold_at = -1;
      chk(last_rx, 8'h96);
      chk(standby_o, 0);
      busy_i = 0;
   endtask

   task automatic t_wp_busy();
      wp_n_i = 0;
      busy_i = 1;
      repeat (10) @(negedge ref_clk_i);
      chk(wp_lock_o, 1);
      frame('{OP_PROT, 8'h00, 8'h00, 8'h00});
      chk(last_blk, 1);
      chk(standby_o, 0);
      wp_n_i = 1;
      busy_i = 0;
      repeat (10) @(negedge ref_clk_i);
      chk(standby_o, 1);
      chk(wp_lock_o, 0);
   endtask

   initial begin
      repeat (5) @(negedge ref_clk_i);
      reset_n_i = 1;
      repeat (5) @(negedge ref_clk_i);
      t_read();
      t_erase();
      t_unsup();
      t_partial();
      t_hold();
      t_wp_busy();
      finish_test();
   end

   initial begin
      #100000;
      errors++;
      finish_test();
   end
endmodule

`default_nettype wire

// >>> sfs_frontend.sv
/*
   Serial flash command front end. The link side runs on the master's
   serial clock and frames opcode, address and data; the core side runs
   on ref_clk_i and hands out decoded commands and received bytes.
   Assumes the core supplies busy, sector protection and read data.
*/
`default_nettype none

module sfs_frontend
   import sfs_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic sck_i,
   input wire logic cs_n_i,
   input wire logic si_i,
   input wire logic hold_n_i,
   input wire logic wp_n_i,
   input wire logic busy_i,
   input wire logic [SECT_CNT-1:0] sect_prot_i,
   input wire logic [7:0] tx_byte_i,
   input wire logic tx_load_i,
   output logic so_o,
   output logic so_oe_n_o,
   output logic cmd_valid_o,
   output sfs_cmd_t cmd_o,
   output logic cmd_blocked_o,
   output logic rx_valid_o,
   output logic [7:0] rx_byte_o,
   output logic frame_end_o,
   output logic hold_o,
   output logic wp_lock_o,
   output logic standby_o
);

   // ---------------- Link side, serial clock ----------------

   logic link_rst_n;
   logic lk_run;
   sfs_lk_state_t st_q;
   sfs_lk_state_t st_d;
   logic [2:0] bit_q;
   logic [1:0] byt_q;
   logic [7:0] sh_q;
   logic [7:0] sh_d;
   logic [7:0] op_q;
   logic [19:0] addr_q;
   logic [7:0] rx_q;
   logic txm_q;
   logic byte_end;
   logic op_end;
   logic adr_step;
   logic dat_end;
   logic hdr_ev;
   logic hdr_tgl_q;
   logic rx_tgl_q;
   logic op_sup;
   logic op_adr;
   logic op_tx;

   // Frame state dies with chip select
   assign link_rst_n = reset_n_i & ~cs_n_i;

   // Held clock edges leave every link flop untouched except the tx_s1_q to tx_s_q toggle synchroniser
   assign lk_run = hold_n_i;

   assign sh_d = {sh_q[6:0], si_i};
   assign byte_end = lk_run && (bit_q == BIT_LAST);
   assign op_end = byte_end && (st_q == LK_OP);
   assign adr_step = byte_end && (st_q == LK_ADR);
   assign dat_end = byte_end && (st_q == LK_DAT);

   // Partial headers never reach the core side
   assign hdr_ev = (op_end && op_sup && !op_adr) ||
                   (adr_step && (byt_q == ADR_LAST));

   sfs_op_dec u_link_dec (
      .op_i(sh_d),
      .addr_i(addr_q),
      .sup_o(op_sup),
      .adr_o(op_adr),
      .tx_o(op_tx),
      .cls_o(),
      .ers_o(),
      .sect_o()
   );

   always_comb begin
      st_d = st_q;
      case (st_q)
         LK_OP: begin
            if (!op_sup)
               st_d = LK_IGN;
            else if (op_adr)
               st_d = LK_ADR;
            else
               st_d = LK_DAT;
         end
         LK_ADR: begin
            if (byt_q == ADR_LAST)
               st_d = LK_DAT;
         end
         LK_DAT:
            st_d = LK_DAT;
         LK_IGN:
            st_d = LK_IGN;
         default:
            st_d = LK_IGN;
      endcase
   end

   // Sampling on the rising edge whatever the idle level
   always_ff @(posedge sck_i or negedge link_rst_n) begin
      if (!link_rst_n) begin
         st_q <= LK_OP;
         bit_q <= 3'h0;
         sh_q <= 8'h00;
      end else if (lk_run) begin
         bit_q <= bit_q + 3'h1;
         sh_q <= sh_d;
         if (byte_end)
            st_q <= st_d;
      end
   end

   always_ff @(posedge sck_i or negedge link_rst_n) begin
      if (!link_rst_n) begin
         op_q <= 8'h00;
         txm_q <= 1'b0;
      end else if (op_end && op_sup) begin
         op_q <= sh_d;
         txm_q <= op_tx;
      end
   end

   // Top address nibble falls off the 20-bit register
   always_ff @(posedge sck_i or negedge link_rst_n) begin
      if (!link_rst_n) begin
         byt_q <= 2'h0;
         addr_q <= 20'h0_0000;
      end else if (adr_step) begin
         byt_q <= byt_q + 2'h1;
         addr_q <= {addr_q[11:0], sh_d};
      end
   end

   always_ff @(posedge sck_i or negedge link_rst_n) begin
      if (!link_rst_n)
         rx_q <= 8'h00;
      else if (dat_end)
         rx_q <= sh_d;
   end

   // Event toggles survive the frame so a release makes no false edge
   always_ff @(posedge sck_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         hdr_tgl_q <= 1'b0;
         rx_tgl_q <= 1'b0;
      end else begin
         if (hdr_ev)
            hdr_tgl_q <= ~hdr_tgl_q;
         if (dat_end)
            rx_tgl_q <= ~rx_tgl_q;
      end
   end

   // ---------------- Link side, output on falling edge ----------------

   logic tx_tgl_q;
   logic [7:0] tx_hold_q;
   logic tx_s1_q;
   logic tx_s2_q;
   logic tx_s3_q;
   logic tx_s_q;
   logic tx_seen_q;
   logic tx_shift;
   logic tx_load;
   logic tx_new;
   logic [7:0] tx_src;
   logic so_q;
   logic [7:0] so_sh_q;

   assign tx_shift = lk_run && txm_q && (st_q == LK_DAT);
   assign tx_load = tx_shift && (bit_q == 3'h0);
   assign tx_new = tx_s_q != tx_seen_q;
   assign tx_src = tx_new ? tx_hold_q : TX_IDLE;

   always_ff @(negedge sck_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         tx_s1_q <= 1'b0;
         tx_s2_q <= 1'b0;
         tx_s3_q <= 1'b0;
      end else begin
         tx_s1_q <= tx_tgl_q;
         tx_s2_q <= tx_s1_q;
         tx_s3_q <= tx_s2_q;
      end
   end

   always_ff @(negedge sck_i or negedge reset_n_i) begin
      if (!reset_n_i)
         tx_s_q <= 1'b0;
      else if (tx_s2_q == tx_s3_q)
         tx_s_q <= tx_s3_q;
   end

   always_ff @(negedge sck_i or negedge reset_n_i) begin
      if (!reset_n_i)
         tx_seen_q <= 1'b0;
      else if (tx_load)
         tx_seen_q <= tx_s_q;
   end

   // Output bits change only on the falling edge
   always_ff @(negedge sck_i or negedge link_rst_n) begin
      if (!link_rst_n) begin
         so_q <= 1'b1;
         so_sh_q <= 8'h00;
      end else if (tx_load) begin
         so_q <= tx_src[7];
         so_sh_q <= {tx_src[6:0], 1'b1};
      end else if (tx_shift) begin
         so_q <= so_sh_q[7];
         so_sh_q <= {so_sh_q[6:0], 1'b1};
      end
   end

   assign so_o = so_q;

   // ---------------- Core side, reference clock ----------------

   logic [6:0] pin_s;
   logic cs_n_s;
   logic hold_n_s;
   logic wp_n_s;
   logic sck_s;
   logic hdr_s;
   logic rx_s;
   logic txm_s;

   sfs_sync #(
      .W(7),
      .RST(PIN_RST)
   ) u_sync (
      .clk_i(ref_clk_i),
      .rst_n_i(reset_n_i),
      .d_i({cs_n_i, hold_n_i, wp_n_i, sck_i, hdr_tgl_q, rx_tgl_q, txm_q}),
      .q_o(pin_s)
   );

   assign cs_n_s = pin_s[6];
   assign hold_n_s = pin_s[5];
   assign wp_n_s = pin_s[4];
   assign sck_s = pin_s[3];
   assign hdr_s = pin_s[2];
   assign rx_s = pin_s[1];
   assign txm_s = pin_s[0];

   logic cs_prev_q;
   logic hold_prev_q;
   logic hold_q;
   logic hold_start;
   logic hdr_seen_q;
   logic rx_seen_q;
   logic stg_q;
   logic [7:0] raw_op_q;
   logic [19:0] raw_addr_q;
   logic hdr_p;
   logic rx_p;
   logic oe_n_d;

   assign hdr_p = hdr_s != hdr_seen_q;
   assign rx_p = rx_s != rx_seen_q;

   // Hold counts only if selected and the clock rests low
   assign hold_start = hold_prev_q && !hold_n_s && !cs_n_s && !sck_s;

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cs_prev_q <= 1'b1;
         hold_prev_q <= 1'b1;
         hdr_seen_q <= 1'b0;
         rx_seen_q <= 1'b0;
      end else begin
         cs_prev_q <= cs_n_s;
         hold_prev_q <= hold_n_s;
         hdr_seen_q <= hdr_s;
         rx_seen_q <= rx_s;
      end
   end

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i)
         hold_q <= 1'b0;
      else if (cs_n_s || hold_n_s)
         hold_q <= 1'b0;
      else if (hold_start)
         hold_q <= 1'b1;
   end

   // Output floats when deselected, held, or the opcode does not set tx-mode (not a read)
   assign oe_n_d = cs_n_s || hold_q || !hold_n_s || !txm_s;

   // Header words are stable on the link until the frame closes
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         stg_q <= 1'b0;
         raw_op_q <= 8'h00;
         raw_addr_q <= 20'h0_0000;
      end else begin
         stg_q <= hdr_p;
         if (hdr_p) begin
            raw_op_q <= op_q;
            raw_addr_q <= addr_q;
         end
      end
   end

   sfs_cls_t dec_cls;
   sfs_ers_t dec_ers;
   logic [4:0] dec_sect;
   logic prot_hit;
   logic top_blk;
   logic span_hit;
   logic blk_d;

   sfs_op_dec u_core_dec (
      .op_i(raw_op_q),
      .addr_i(raw_addr_q),
      .sup_o(),
      .adr_o(),
      .tx_o(),
      .cls_o(dec_cls),
      .ers_o(dec_ers),
      .sect_o(dec_sect)
   );

   assign prot_hit = sect_prot_i[dec_sect];
   assign top_blk = raw_addr_q[19:16] == TOP_BLK;

   // Large erases in the top block cover several small sectors
   assign span_hit = (dec_ers == ERS_CHIP) ? |sect_prot_i :
                     (top_blk && dec_ers == ERS_64K) ?
                        |sect_prot_i[SECT_CNT-1:SECT_CNT-4] :
                     (top_blk && dec_ers == ERS_32K && !raw_addr_q[15]) ?
                        |sect_prot_i[SECT_CNT-2:SECT_CNT-4] :
                     prot_hit;

   assign blk_d = ((dec_cls == OC_PROG) && prot_hit) ||
                  ((dec_cls == OC_ERASE) && span_hit) ||
                  ((dec_cls == OC_PROT) && wp_lock_o);

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cmd_valid_o <= 1'b0;
         cmd_blocked_o <= 1'b0;
         cmd_o <= '0;
      end else begin
         cmd_valid_o <= stg_q;
         if (stg_q) begin
            cmd_blocked_o <= blk_d;
            cmd_o <= '{raw_op_q, raw_addr_q, dec_cls, dec_ers, dec_sect};
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rx_valid_o <= 1'b0;
         rx_byte_o <= 8'h00;
      end else begin
         rx_valid_o <= rx_p;
         if (rx_p)
            rx_byte_o <= rx_q;
      end
   end

   // Read data for the link, flagged by a toggle
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         tx_hold_q <= TX_IDLE;
         tx_tgl_q <= 1'b0;
      end else if (tx_load_i) begin
         tx_hold_q <= tx_byte_i;
         tx_tgl_q <= ~tx_tgl_q;
      end
   end

   // Busy is a core level and ignores hold entirely
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         so_oe_n_o <= 1'b1;
         frame_end_o <= 1'b0;
         hold_o <= 1'b0;
         wp_lock_o <= 1'b0;
         standby_o <= 1'b1;
      end else begin
         so_oe_n_o <= oe_n_d;
         frame_end_o <= !cs_prev_q && cs_n_s;
         hold_o <= hold_q;
         wp_lock_o <= !wp_n_s;
         standby_o <= cs_n_s && !busy_i;
      end
   end

endmodule

`default_nettype wire

// >>> sfs_frontend_props.sv
/*
   Concurrent checks on the ports of the command front end.
   Assumes sfs_pkg is compiled first; bound into every sfs_frontend.
*/
`default_nettype none

module sfs_frontend_props
   import sfs_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic cs_n_i,
   input wire logic hold_n_i,
   input wire logic wp_n_i,
   input wire logic busy_i,
   input wire logic [SECT_CNT-1:0] sect_prot_i,
   input wire logic so_oe_n_o,
   input wire logic cmd_valid_o,
   input wire sfs_cmd_t cmd_o,
   input wire logic cmd_blocked_o,
   input wire logic rx_valid_o,
   input wire logic frame_end_o,
   input wire logic hold_o,
   input wire logic wp_lock_o,
   input wire logic standby_o
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!reset_n_i);

   chk_desel_float: assert property (cs_n_i [*8] |-> so_oe_n_o)
      else $error("output driven while deselected");
   chk_hold_float: assert property (!hold_n_i [*8] |-> so_oe_n_o)
      else $error("output driven during hold");
   chk_hold_needs_cs: assert property (cs_n_i [*8] |-> !hold_o)
      else $error("hold reported while deselected");
   chk_frame_end: assert property ($rose(cs_n_i) |-> ##[3:8] frame_end_o)
      else $error("no frame end after release");
   chk_busy_standby: assert property (
      (busy_i || !cs_n_i) [*8] |-> !standby_o)
      else $error("standby while selected or busy");
   chk_no_unsup: assert property (
      cmd_valid_o |-> cmd_o.cls != OC_NONE)
      else $error("command reported without class");
   chk_pulse_once: assert property (
      cmd_valid_o || rx_valid_o |=> !cmd_valid_o && !rx_valid_o)
      else $error("pulse longer than one cycle");
   chk_wp_on: assert property (!wp_n_i [*7] |-> wp_lock_o)
      else $error("lock missing with protect low");
   chk_wp_off: assert property (wp_n_i [*7] |-> !wp_lock_o)
      else $error("lock set with protect high");
   // Only targets that lie inside a single sector
   chk_sect_block: assert property (
      cmd_valid_o && (cmd_o.cls == OC_PROG || cmd_o.ers == ERS_4K ||
      (cmd_o.cls == OC_ERASE && cmd_o.ers != ERS_CHIP &&
      cmd_o.addr[19:16] != TOP_BLK))
      |-> cmd_blocked_o == sect_prot_i[cmd_o.sect])
      else $error("sector block flag wrong");
   chk_chip_block: assert property (
      cmd_valid_o && cmd_o.ers == ERS_CHIP
      |-> cmd_blocked_o == |sect_prot_i)
      else $error("chip erase block flag wrong");
   chk_wp_block: assert property (
      cmd_valid_o && cmd_o.cls == OC_PROT && wp_lock_o |-> cmd_blocked_o)
      else $error("protection change not blocked");

   cov_blocked: cover property (cmd_valid_o && cmd_blocked_o);
   cov_rx: cover property (rx_valid_o);
   cov_hold: cover property (hold_o);
endmodule

bind sfs_frontend sfs_frontend_props u_props (
   .ref_clk_i, .reset_n_i, .cs_n_i, .hold_n_i, .wp_n_i, .busy_i,
   .sect_prot_i, .so_oe_n_o, .cmd_valid_o, .cmd_o, .cmd_blocked_o,
   .rx_valid_o, .frame_end_o, .hold_o, .wp_lock_o, .standby_o
);

`default_nettype wire

// >>> sfs_master_model.sv
/*
   Behavioural host master on the serial link: modes 0 and 3, whole or
   partial bytes, hold pauses. Assumes the bench calls its tasks; the
   serial clock stands still outside frames.
*/
`default_nettype none

module sfs_master_model (
   input wire logic cpol_i,
   input wire logic so_i,
   input wire logic so_oe_n_i,
   output logic sck_o,
   output logic cs_n_o,
   output logic si_o,
   output logic hold_n_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] rx = '0;
   logic so_w;

   // Floating output reads as a changing pattern
   assign so_w = so_oe_n_i ? ~rx[0] : so_i;

   initial begin
      sck_o = 1'b0;
      cs_n_o = 1'b1;
      si_o = 1'b0;
      hold_n_o = 1'b1;
   end

   task automatic sel();
      sck_o = cpol_i;
      #20 cs_n_o = 1'b0;
      #15;
   endtask

   // Shifts the top n bits of d
   task automatic bits(input logic [7:0] d, input int n);
      for (int i = 7; i > 7 - n; i--) begin
         sck_o = 1'b0;
         si_o = d[i];
         #15 sck_o = 1'b1;
         rx = {rx[6:0], so_w};
         #15;
      end
   endtask

   task automatic desel();
      sck_o = cpol_i;
      #15 cs_n_o = 1'b1;
      si_o = ~si_o;
      #30;
   endtask

   task automatic hold_on();
      sck_o = 1'b0;
      #30 hold_n_o = 1'b0;
      #15;
      repeat (3) begin
         sck_o = 1'b1;
         si_o = ~si_o;
         #15 sck_o = 1'b0;
         #15;
      end
   endtask

   task automatic hold_off();
      hold_n_o = 1'b1;
      #15;
   endtask
endmodule

`default_nettype wire

// >>> sfs_op_dec.sv
/*
   Opcode and address decoder: support, operand shape, command class,
   erase size and protection sector. Purely combinational.
*/
`default_nettype none

module sfs_op_dec
   import sfs_pkg::*;
(
   input wire logic [7:0] op_i,
   input wire logic [19:0] addr_i,
   output logic sup_o,
   output logic adr_o,
   output logic tx_o,
   output sfs_cls_t cls_o,
   output sfs_ers_t ers_o,
   output logic [4:0] sect_o
);

   always_comb begin
      sup_o = 1'b1;
      adr_o = 1'b0;
      tx_o = 1'b0;
      cls_o = OC_MISC;
      ers_o = ERS_NONE;
      case (op_i)
         OP_RD_FAST, OP_RD_SLOW: begin
            adr_o = 1'b1;
            tx_o = 1'b1;
            cls_o = OC_READ;
         end
         OP_ERS_4K, OP_ERS_32K, OP_ERS_64K: begin
            adr_o = 1'b1;
            cls_o = OC_ERASE;
            ers_o = (op_i == OP_ERS_4K) ? ERS_4K :
                    (op_i == OP_ERS_32K) ? ERS_32K : ERS_64K;
         end
         OP_ERS_CHIP_A, OP_ERS_CHIP_B: begin
            cls_o = OC_ERASE;
            ers_o = ERS_CHIP;
         end
         OP_PROG, OP_SEQ_A, OP_SEQ_B: begin
            adr_o = 1'b1;
            cls_o = OC_PROG;
         end
         OP_PROT, OP_UNPROT: begin
            adr_o = 1'b1;
            cls_o = OC_PROT;
         end
         OP_WR_STAT:
            cls_o = OC_PROT;
         OP_RD_PROT: begin
            adr_o = 1'b1;
            tx_o = 1'b1;
            cls_o = OC_READ;
         end
         OP_RD_STAT, OP_RD_ID: begin
            tx_o = 1'b1;
            cls_o = OC_READ;
         end
         OP_WR_EN, OP_WR_DIS, OP_PWR_DN, OP_PWR_UP:
            cls_o = OC_MISC;
         default: begin
            sup_o = 1'b0;
            cls_o = OC_NONE;
         end
      endcase
   end

   // Uniform 64KB sectors below the top block, mixed sizes inside it
   assign sect_o = (addr_i[19:16] != TOP_BLK) ? {1'b0, addr_i[19:16]} :
                   (addr_i[15:14] == 2'b00) ? SECT_16K :
                   (addr_i[15:13] == 3'b010) ? SECT_8K_LO :
                   (addr_i[15:13] == 3'b011) ? SECT_8K_HI :
                   SECT_32K;

endmodule

`default_nettype wire

// >>> sfs_pkg.sv
/*
   Constants and types of the serial flash command front end: opcodes,
   erase granularities, sector map, link states and the command record.
   Assumes a SystemVerilog-2012 tool flow; shared by all design files except the pin synchroniser.
*/
`default_nettype none

package sfs_pkg;

   localparam logic [7:0] OP_RD_FAST = 8'h0B;
   localparam logic [7:0] OP_RD_SLOW = 8'h03;
   localparam logic [7:0] OP_ERS_4K = 8'h20;
   localparam logic [7:0] OP_ERS_32K = 8'h52;
   localparam logic [7:0] OP_ERS_64K = 8'hD8;
   localparam logic [7:0] OP_ERS_CHIP_A = 8'h60;
   localparam logic [7:0] OP_ERS_CHIP_B = 8'hC7;
   localparam logic [7:0] OP_PROG = 8'h02;
   localparam logic [7:0] OP_SEQ_A = 8'hAD;
   localparam logic [7:0] OP_SEQ_B = 8'hAF;
   localparam logic [7:0] OP_WR_EN = 8'h06;
   localparam logic [7:0] OP_WR_DIS = 8'h04;
   localparam logic [7:0] OP_PROT = 8'h36;
   localparam logic [7:0] OP_UNPROT = 8'h39;
   localparam logic [7:0] OP_RD_PROT = 8'h3C;
   localparam logic [7:0] OP_RD_STAT = 8'h05;
   localparam logic [7:0] OP_WR_STAT = 8'h01;
   localparam logic [7:0] OP_RD_ID = 8'h9F;
   localparam logic [7:0] OP_PWR_DN = 8'hB9;
   localparam logic [7:0] OP_PWR_UP = 8'hAB;

   localparam int SECT_CNT = 19;
   localparam logic [3:0] TOP_BLK = 4'hF;
   localparam logic [4:0] SECT_16K = 5'h0F;
   localparam logic [4:0] SECT_8K_LO = 5'h10;
   localparam logic [4:0] SECT_8K_HI = 5'h11;
   localparam logic [4:0] SECT_32K = 5'h12;

   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [1:0] ADR_LAST = 2'h2;
   localparam logic [7:0] TX_IDLE = 8'hFF;
   // Idle levels of {cs_n, hold_n, wp_n, sck, hdr, rx, tx-mode}
   localparam logic [6:0] PIN_RST = 7'h70;

   typedef enum logic [1:0] {
      LK_OP = 2'b00,
      LK_ADR = 2'b01,
      LK_DAT = 2'b10,
      LK_IGN = 2'b11
   } sfs_lk_state_t;

   typedef enum logic [2:0] {
      OC_NONE = 3'b000,
      OC_READ = 3'b001,
      OC_ERASE = 3'b010,
      OC_PROG = 3'b011,
      OC_PROT = 3'b100,
      OC_MISC = 3'b101
   } sfs_cls_t;

   typedef enum logic [2:0] {
      ERS_NONE = 3'b000,
      ERS_4K = 3'b001,
      ERS_32K = 3'b010,
      ERS_64K = 3'b011,
      ERS_CHIP = 3'b100
   } sfs_ers_t;

   typedef struct packed {
      logic [7:0] op;
      logic [19:0] addr;
      sfs_cls_t cls;
      sfs_ers_t ers;
      logic [4:0] sect;
   } sfs_cmd_t;

endpackage

`default_nettype wire

// >>> sfs_sync.sv
/*
   Pin synchroniser: three stages and an output flip-flop per bit; the output follows once
   the second and third stages agree. Assumes a free-running clock.
*/
`default_nettype none

module sfs_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);

   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s1_q <= RST;
         s2_q <= RST;
         s3_q <= RST;
      end else begin
         s1_q <= d_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   for (genvar i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk_i or negedge rst_n_i) begin
         if (!rst_n_i)
            q_o[i] <= RST[i];
         else if (s2_q[i] == s3_q[i])
            q_o[i] <= s3_q[i];
      end
   end

endmodule

`default_nettype wire
